// File: flash_pe_pkg.sv
// Constants and types for the flash program/erase protection block.
// Assumes an 8-bit register port and a single 100 MHz clock domain.
package flash_pe_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int BLK_W = 8;

  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h01;
  localparam logic [7:0] OFS_EBS_ONE = 8'h02;
  localparam logic [7:0] OFS_EBS_TWO = 8'h03;
  localparam logic [7:0] OFS_INT_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_MASK = 8'h05;
  localparam logic [7:0] OFS_STATE = 8'h06;

  localparam int ERR_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] EBS_RESET = 8'h00;
  localparam logic [1:0] INT_RESET = 2'h0;
  localparam int EV_ERROR = 0;
  localparam int EV_DONE = 1;

  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_AUTO_PROG = 8'h40;
  localparam logic [7:0] CMD_AUTO_ERASE = 8'h20;
  localparam logic [7:0] CMD_STATUS = 8'h71;
  localparam logic [7:0] AUTO_PROG_BYTES = 8'h80;
  localparam logic [7:0] BYTE_LAST = 8'h7F;

  typedef struct packed {
    logic swe;
    logic esu;
    logic psu;
    logic ev;
    logic pv;
    logic e;
    logic p;
  } ctrl_t;

  typedef struct packed {
    logic flash_read;
    logic exception_start;
    logic sleep_exec;
  } cpu_event_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [2:0] {
    PM_READ = 3'b000,
    PM_PROG_ADDR = 3'b001,
    PM_PROG_DATA = 3'b010,
    PM_ERASE_CONF = 3'b011,
    PM_STATUS_CONF = 3'b100,
    PM_BUSY = 3'b101,
    PM_STATUS = 3'b110
  } pm_state_t;

endpackage

// File: flash_pe_protect.sv
// Flash program/erase protection: control registers, error protection,
// interrupt masking and the programmer-mode command sequencer.
// Assumes CPU event strobes and pins are synchronous to ref_clk.
`timescale 1ns/1ns
module flash_pe_protect (
  input wire logic ref_clk,
  input wire logic rst,
  input wire flash_pe_pkg::reg_req_t reg_req,
  output logic [flash_pe_pkg::DATA_W-1:0] rdata,
  input wire logic flash_write_enable_pin,
  input wire logic standby_entry,
  input wire logic hw_standby,
  input wire logic boot_running,
  input wire flash_pe_pkg::cpu_event_t cpu_event,
  output logic program_mode_one,
  output logic program_mode_two,
  output logic erase_mode_one,
  output logic erase_mode_two,
  output logic verify_mode_one,
  output logic verify_mode_two,
  output logic [flash_pe_pkg::BLK_W-1:0] erase_enable_one,
  output logic [flash_pe_pkg::BLK_W-1:0] erase_enable_two,
  output logic cpu_int_mask,
  output logic read_data_invalid,
  output logic irq,
  input wire logic pm_cmd_wr,
  input wire logic [7:0] pm_cmd_data,
  input wire logic pm_auto_done,
  input wire logic pm_auto_fail,
  output logic pm_start_prog,
  output logic pm_start_erase,
  output logic [7:0] pm_status
);
  import flash_pe_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  ctrl_t ctrl_one;
  ctrl_t ctrl_two;
  logic [BLK_W-1:0] ebs_one;
  logic [BLK_W-1:0] ebs_two;
  logic flash_error_flag;
  logic [1:0] int_status;
  logic [1:0] int_mask;
  logic pe_active_q;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_ctrl_one = reg_req.wr && reg_req.addr == OFS_CTRL_ONE;
  wire wr_ctrl_two = reg_req.wr && reg_req.addr == OFS_CTRL_TWO;
  wire wr_ebs_one = reg_req.wr && reg_req.addr == OFS_EBS_ONE;
  wire wr_ebs_two = reg_req.wr && reg_req.addr == OFS_EBS_TWO;
  wire wr_int_status = reg_req.wr && reg_req.addr == OFS_INT_STATUS;
  wire wr_int_mask = reg_req.wr && reg_req.addr == OFS_INT_MASK;
  wire ctrl_t wctrl = ctrl_t'(reg_req.wdata[6:0]);

  wire pin_clear = !flash_write_enable_pin;
  wire reg_clear = pin_clear || standby_entry || hw_standby;

  // Any program or erase bit set in either control register
  wire pe_bits_set = ctrl_one.p || ctrl_one.e || ctrl_two.p || ctrl_two.e;

  wire err_event = pe_bits_set &&
    (cpu_event.flash_read || cpu_event.exception_start ||
     cpu_event.sleep_exec);

  ////////////////////////////////////////////////////////////////////////
  // Mode outputs
  // write-enable gating, abort on error
  wire run_one = ctrl_one.swe && !flash_error_flag;
  wire run_two = ctrl_two.swe && !flash_error_flag;
  // set one main region, set two upper region
  assign program_mode_one = run_one && ctrl_one.p;
  assign program_mode_two = run_two && ctrl_two.p;
  assign erase_mode_one = run_one && ctrl_one.e;
  assign erase_mode_two = run_two && ctrl_two.e;
  assign verify_mode_one = ctrl_one.swe && (ctrl_one.pv || ctrl_one.ev);
  assign verify_mode_two = ctrl_two.swe && (ctrl_two.pv || ctrl_two.ev);
  assign erase_enable_one = erase_mode_one ? ebs_one : '0;
  assign erase_enable_two = erase_mode_two ? ebs_two : '0;

  assign cpu_int_mask = pe_bits_set || boot_running;
  assign read_data_invalid = pe_bits_set;

  wire pe_active = program_mode_one || program_mode_two ||
    erase_mode_one || erase_mode_two;
  wire done_event = pe_active_q && !pe_active;

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_one <= ctrl_t'(CTRL_RESET[6:0]);
    end else if (reg_clear) begin
      ctrl_one <= ctrl_t'(CTRL_RESET[6:0]);
    end else if (wr_ctrl_one) begin
      ctrl_one <= wctrl;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_two <= ctrl_t'(CTRL_RESET[6:0]);
    end else if (reg_clear) begin
      ctrl_two <= ctrl_t'(CTRL_RESET[6:0]);
    end else if (wr_ctrl_two) begin
      ctrl_two <= wctrl;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ebs_one <= EBS_RESET;
      ebs_two <= EBS_RESET;
    end else if (reg_clear) begin
      ebs_one <= EBS_RESET;
      ebs_two <= EBS_RESET;
    end else begin
      if (wr_ebs_one) begin
        ebs_one <= reg_req.wdata;
      end
      if (wr_ebs_two) begin
        ebs_two <= reg_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error flag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flash_error_flag <= 1'b0;
    end else if (err_event) begin
      flash_error_flag <= 1'b1;
    end else if (hw_standby) begin
      flash_error_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event status and mask
  wire [1:0] ev_set = {done_event, err_event && !flash_error_flag};
  wire [1:0] w1c = wr_int_status ? reg_req.wdata[1:0] : 2'h0;
  wire [1:0] next_int_status = ev_set | (int_status & ~w1c);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      int_status <= INT_RESET;
      int_mask <= INT_RESET;
      pe_active_q <= 1'b0;
    end else begin
      int_status <= next_int_status;
      pe_active_q <= pe_active;
      if (wr_int_mask) begin
        int_mask <= reg_req.wdata[1:0];
      end
    end
  end

  assign irq = |(int_status & int_mask);

  ////////////////////////////////////////////////////////////////////////
  // Read path
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    case (reg_req.addr)
      OFS_CTRL_ONE: rd_mux = {1'b0, ctrl_one};
      OFS_CTRL_TWO: rd_mux = {flash_error_flag, ctrl_two};
      OFS_EBS_ONE: rd_mux = ebs_one;
      OFS_EBS_TWO: rd_mux = ebs_two;
      OFS_INT_STATUS: rd_mux = {6'h00, int_status};
      OFS_INT_MASK: rd_mux = {6'h00, int_mask};
      OFS_STATE: rd_mux = {4'h0, cpu_int_mask, pe_active,
                           verify_mode_two, verify_mode_one};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= reg_req.rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // programmer mode sequencer
  pm_state_t pm_state;
  pm_state_t next_pm_state;
  logic [7:0] pm_count;
  logic pm_done;
  logic pm_fail;
  logic pm_prog;

  always_comb begin
    next_pm_state = pm_state;
    case (pm_state)
      PM_READ, PM_STATUS: begin
        if (pm_cmd_wr) begin
          case (pm_cmd_data)
            CMD_AUTO_PROG: next_pm_state = PM_PROG_ADDR;
            CMD_AUTO_ERASE: next_pm_state = PM_ERASE_CONF;
            CMD_STATUS: next_pm_state = PM_STATUS_CONF;
            default: next_pm_state = PM_READ;
          endcase
        end
      end
      PM_PROG_ADDR: begin
        if (pm_cmd_wr) begin
          next_pm_state = PM_PROG_DATA;
        end
      end
      PM_PROG_DATA: begin
        if (pm_cmd_wr && pm_count == BYTE_LAST) begin
          next_pm_state = PM_BUSY;
        end
      end
      PM_ERASE_CONF: begin
        if (pm_cmd_wr) begin
          next_pm_state = pm_cmd_data == CMD_AUTO_ERASE ? PM_BUSY : PM_READ;
        end
      end
      PM_STATUS_CONF: begin
        if (pm_cmd_wr) begin
          next_pm_state = pm_cmd_data == CMD_STATUS ? PM_STATUS : PM_READ;
        end
      end
      PM_BUSY: begin
        if (pm_auto_done) begin
          next_pm_state = PM_STATUS;
        end
      end
      default: next_pm_state = PM_READ;
    endcase
  end

  wire pm_enter_busy = next_pm_state == PM_BUSY && pm_state != PM_BUSY;
  wire pm_count_step = pm_state == PM_PROG_DATA && pm_cmd_wr;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pm_state <= PM_READ;
      pm_count <= 8'h00;
      pm_done <= 1'b0;
      pm_fail <= 1'b0;
      pm_prog <= 1'b0;
      pm_start_prog <= 1'b0;
      pm_start_erase <= 1'b0;
    end else begin
      pm_state <= next_pm_state;
      pm_count <= pm_count_step ? pm_count + 8'h01 :
                  (pm_state == PM_PROG_DATA ? pm_count : 8'h00);
      pm_start_prog <= pm_enter_busy && pm_state == PM_PROG_DATA;
      pm_start_erase <= pm_enter_busy && pm_state == PM_ERASE_CONF;
      if (pm_enter_busy) begin
        pm_done <= 1'b0;
        pm_fail <= 1'b0;
        pm_prog <= pm_state == PM_PROG_DATA;
      end else if (pm_state == PM_BUSY && pm_auto_done) begin
        pm_done <= 1'b1;
        pm_fail <= pm_auto_fail;
      end
    end
  end

  // Status: bit7 done, bit6 normal end, bit5 fail, bit4 last was program
  assign pm_status = {pm_done, pm_done && !pm_fail, pm_fail, pm_prog,
                      4'h0};

endmodule // flash_pe_protect

// File: flash_pe_protect_assertions.sv
// Port-level checker for flash_pe_protect.
// Assumes binding to the design top module; single ref_clk domain.
`timescale 1ns/1ns
module flash_pe_protect_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire flash_pe_pkg::reg_req_t reg_req,
  input wire logic [7:0] rdata,
  input wire logic flash_write_enable_pin,
  input wire logic standby_entry,
  input wire logic hw_standby,
  input wire logic boot_running,
  input wire flash_pe_pkg::cpu_event_t cpu_event,
  input wire logic program_mode_one,
  input wire logic program_mode_two,
  input wire logic erase_mode_one,
  input wire logic erase_mode_two,
  input wire logic [7:0] erase_enable_one,
  input wire logic [7:0] erase_enable_two,
  input wire logic cpu_int_mask,
  input wire logic read_data_invalid
);
  import flash_pe_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic err_seen;
  wire any_mode = program_mode_one | program_mode_two | erase_mode_one |
    erase_mode_two;
  wire fault = read_data_invalid && (cpu_event != 3'h0);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) err_seen <= 1'b0;
    else if (fault) err_seen <= 1'b1;
    else if (hw_standby) err_seen <= 1'b0;
  end
  //////////////////////////////////////////////////////////////////
  sequence s_fault(ev);
    read_data_invalid && ev;
  endsequence
  property p_abort(ev);
    s_fault(ev) |=> !any_mode;
  endproperty
  a_hw_clear: assert property (
    (!flash_write_enable_pin || standby_entry || hw_standby) |=> !any_mode)
    else $error("mode active after protection clear");
  a_read_abort: assert property (p_abort(cpu_event.flash_read))
    else $error("mode kept after flash read");
  a_exc_abort: assert property (p_abort(cpu_event.exception_start))
    else $error("mode kept after exception");
  a_sleep_abort: assert property (p_abort(cpu_event.sleep_exec))
    else $error("mode kept after sleep");
  a_err_hold: assert property (err_seen |-> !any_mode)
    else $error("mode re-entered under error protection");
  a_block_gate: assert property (
    (erase_enable_one == 8'h00 || erase_mode_one) &&
    (erase_enable_two == 8'h00 || erase_mode_two))
    else $error("block enabled outside erase mode");
  a_mask_level: assert property (
    cpu_int_mask == (read_data_invalid || boot_running) &&
    (!any_mode || read_data_invalid))
    else $error("interrupt mask wrong");
  a_rdata_idle: assert property (!$past(reg_req.rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_err_readback: assert property (
    $past(err_seen) && $past(reg_req.rd) && !$past(hw_standby) &&
    $past(reg_req.addr) == OFS_CTRL_TWO |-> rdata[ERR_BIT])
    else $error("error flag not read back");
endmodule // flash_pe_protect_assertions
bind flash_pe_protect flash_pe_protect_assertions u_chk (.ref_clk, .rst,
  .reg_req, .rdata, .flash_write_enable_pin, .standby_entry, .hw_standby,
  .boot_running, .cpu_event, .program_mode_one, .program_mode_two,
  .erase_mode_one, .erase_mode_two, .erase_enable_one, .erase_enable_two,
  .cpu_int_mask, .read_data_invalid);

// File: cpu_core_model.sv
// Processor core stand-in: issues read, exception and sleep events.
// Assumes the bench requests an event one cycle ahead.
`timescale 1ns/1ns
module cpu_core_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] fire,
  input wire logic flash_write_enable_pin,
  output flash_pe_pkg::cpu_event_t cpu_event,
  output logic int_src_en
);
  import flash_pe_pkg::*;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) cpu_event <= '0;
    else cpu_event <= cpu_event_t'(fire);
  end
  assign int_src_en = !flash_write_enable_pin;
endmodule // cpu_core_model

// File: flash_pe_protect_tb.sv
// Self-checking bench for flash_pe_protect.
// Assumes the core model drives CPU events; 100 MHz clock.
`timescale 1ns/1ns
module flash_pe_protect_tb;
  import flash_pe_pkg::*;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
  logic ref_clk = 0, rst = 1, flash_write_enable_pin = 1, standby_entry = 0;
  logic hw_standby = 0, boot_running = 0, pm_cmd_wr = 0, pm_auto_done = 0;
  logic [7:0] pm_cmd_data = 0, rdata, erase_enable_one, erase_enable_two;
  logic [7:0] pm_status;
  logic [2:0] fire = 0;
  logic pm_auto_fail = 1'b0;
  reg_req_t reg_req = '0;
  cpu_event_t cpu_event;
  logic program_mode_one, program_mode_two, erase_mode_one, erase_mode_two;
  logic verify_mode_one, verify_mode_two, cpu_int_mask, read_data_invalid;
  logic irq, pm_start_prog, pm_start_erase;
  int err_total = 0, n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  cpu_core_model u_cpu (.ref_clk, .rst, .fire, .flash_write_enable_pin,
    .cpu_event, .int_src_en());
  flash_pe_protect u_dut (.ref_clk, .rst, .reg_req, .rdata,
    .flash_write_enable_pin, .standby_entry, .hw_standby, .boot_running,
    .cpu_event, .program_mode_one, .program_mode_two, .erase_mode_one,
    .erase_mode_two, .verify_mode_one, .verify_mode_two, .erase_enable_one,
    .erase_enable_two, .cpu_int_mask, .read_data_invalid, .irq, .pm_cmd_wr,
    .pm_cmd_data, .pm_auto_done, .pm_auto_fail, .pm_start_prog,
    .pm_start_erase, .pm_status);
  //////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic fire_ev(input logic [2:0] m);
    @(posedge ref_clk);
    fire <= m;
    @(posedge ref_clk);
    fire <= 3'h0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // Kind 0 pin low, 1 standby, 2 hardware standby, 3 reset
  task automatic pulse(input int k);
    @(posedge ref_clk);
    {rst, hw_standby, standby_entry, flash_write_enable_pin} <=
      4'h1 ^ (4'h1 << k);
    @(posedge ref_clk);
    {rst, hw_standby, standby_entry, flash_write_enable_pin} <= 4'h1;
  endtask
  task automatic pm_wr(input logic [7:0] d);
    @(posedge ref_clk);
    {pm_cmd_wr, pm_cmd_data} <= {1'b1, d};
    @(posedge ref_clk);
    pm_cmd_wr <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  task automatic t_sw;
    for (int i = 0; i < 8; i++) rd_chk(8'(i), 8'h00);
    wr(OFS_CTRL_ONE, 8'h01);
    `CHK(program_mode_one, 1'b0)
    `CHK(cpu_int_mask, 1'b1)
    wr(OFS_CTRL_TWO, 8'h41);
    `CHK(program_mode_two, 1'b1)
    `CHK(read_data_invalid, 1'b1)
    wr(OFS_CTRL_ONE, 8'h00);
    wr(OFS_CTRL_TWO, 8'h00);
    `CHK(cpu_int_mask, 1'b0)
    wr(OFS_CTRL_ONE, 8'h42);
    `CHK(erase_enable_one, 8'h00)
    wr(OFS_EBS_ONE, 8'h04);
    `CHK(erase_enable_one, 8'h04)
    wr(OFS_CTRL_ONE, 8'h00);
    $display("software protection done");
  endtask
  task automatic t_err;
    wr(OFS_CTRL_ONE, 8'h41);
    fire_ev(3'b100);
    `CHK(program_mode_one, 1'b0)
    `CHK({cpu_int_mask, irq}, 2'b10)
    wr(OFS_INT_MASK, 8'h01);
    `CHK(irq, 1'b1)
    rd_chk(OFS_CTRL_ONE, 8'h41);
    wr(OFS_CTRL_ONE, 8'h41);
    `CHK(program_mode_one, 1'b0)
    wr(OFS_CTRL_ONE, 8'h44);
    `CHK(verify_mode_one, 1'b1)
    wr(OFS_CTRL_TWO, 8'h48);
    `CHK(verify_mode_two, 1'b1)
    wr(OFS_CTRL_TWO, 8'h00);
    rd_chk(OFS_CTRL_TWO, 8'h80);
    wr(OFS_INT_STATUS, 8'h01);
    `CHK(irq, 1'b0)
    pulse(2);
    rd_chk(OFS_CTRL_TWO, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL_TWO, 8'h42);
      fire_ev(3'(1 << i));
      `CHK(erase_mode_two, 1'b0)
      rd_chk(OFS_CTRL_TWO, 8'hC2);
      pulse(2);
    end
    fire_ev(3'b111);
    rd_chk(OFS_CTRL_TWO, 8'h00);
    $display("error protection done");
  endtask
  task automatic t_hw;
    logic seen;
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CTRL_ONE, 8'h41);
      wr(OFS_EBS_TWO, 8'h01);
      pulse(k);
      rd_chk(OFS_CTRL_ONE, 8'h00);
      rd_chk(OFS_EBS_TWO, 8'h00);
    end
    @(posedge ref_clk);
    boot_running <= 1'b1;
    #1;
    `CHK(cpu_int_mask, 1'b1)
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      {pm_cmd_wr, pm_cmd_data, boot_running} <= {1'b1, CMD_AUTO_ERASE, 1'b0};
      @(posedge ref_clk);
      pm_cmd_wr <= 1'b0;
    end
    seen = 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      #1;
      seen = (pm_start_erase === 1'b1);
      @(posedge ref_clk);
    end
    `CHK(seen, 1'b1)
    if (!seen) end_of_test();
    pm_auto_done <= 1'b1;
    @(posedge ref_clk);
    pm_auto_done <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK(pm_status[7:6], 2'b11)
    $display("hardware protection done");
  endtask
  task automatic t_pm;
    logic seen;
    pm_wr(CMD_STATUS);
    pm_wr(CMD_STATUS);
    pm_wr(CMD_AUTO_PROG);
    pm_wr(8'h00);
    for (int i = 0; i < int'(AUTO_PROG_BYTES); i++) pm_wr(8'hFF);
    seen = 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      #1;
      seen = (pm_start_prog === 1'b1);
      @(posedge ref_clk);
    end
    `CHK(seen, 1'b1)
    if (!seen) end_of_test();
    #1;
    `CHK(pm_status, 8'h10)
    @(posedge ref_clk);
    {pm_auto_done, pm_auto_fail} <= 2'h3;
    @(posedge ref_clk);
    {pm_auto_done, pm_auto_fail} <= 2'h0;
    @(posedge ref_clk);
    #1;
    `CHK(pm_status, 8'hB0)
    $display("programmer mode done");
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_sw();
    t_err();
    t_hw();
    t_pm();
    end_of_test();
  end
endmodule // flash_pe_protect_tb
